/* File: core/pmd_pkg.sv */
/*
 * Constants shared by the peripheral disable block: register map, field
 * positions, unit indices and start-up timing.
 * Assumes a 100 MHz system clock and a 32-bit APB bus.
 */
package pmd_pkg;
    // ============================================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL0 = 12'h000; // Misc unit disables
    localparam logic [11:0] ADDR_TIMERS = 12'h004; // Timer and oscillator disables
    localparam logic [7:0] CTRL_RESET = 8'h00; // All units enabled
    localparam logic [7:0] CTRL0_IMPL_MASK = 8'hc7; // Bits 5..3 not built
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ============================================================
    // Field positions in the first control register
    localparam int SYS_CLOCK_NET_OFF_BIT = 7;
    localparam int VOLTAGE_REF_OFF_BIT = 6;
    localparam int NONVOLATILE_UNIT_OFF_BIT = 2;
    localparam int CLOCK_REF_OUT_OFF_BIT = 1;
    localparam int PIN_CHANGE_IRQ_OFF_BIT = 0;

    // ============================================================
    // Unit indices on the gated-peripheral ports
    localparam int NUM_UNITS = 12;
    localparam int UNIT_PIN_CHANGE = 0;
    localparam int UNIT_CLOCK_REF = 1;
    localparam int UNIT_NVM = 2;
    localparam int UNIT_VREF = 3;
    localparam int UNIT_TIMER0 = 4; // Timers 0..6 at 4..10
    localparam int UNIT_NUMERIC_OSC = 11;

    // ============================================================
    // Start-up timing after a unit is enabled again
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 125;
    localparam int NVM_WAKE_NS = 1000;
    localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVM_CYCLES = (NVM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 7;
endpackage

/* File: core/pmd_ctrl.sv */
/*
 * Peripheral disable controller: two software registers on APB, and per-unit
 * clock enable, reset hold, register-access gating and output forcing.
 * Assumes the gated units sit on the same system clock and expose an
 * 8-bit register read port, a write strobe and a digital output each.
 */
// The placing of the registers and register access over APB are this design's own decisions.
module pmd_ctrl
    import pmd_pkg::*;
#(
    parameter int N = NUM_UNITS, // Number of gated units
    parameter logic [NUM_UNITS-1:0] USES_SYSCLK = 12'hfff // Units fed by the network
) (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [N-1:0] I_UNIT_WE,
    input wire logic [N*8-1:0] I_UNIT_RDATA,
    input wire logic [N-1:0] I_UNIT_DOUT,
    output logic [N-1:0] O_UNIT_CLK_EN,
    output logic [N-1:0] O_UNIT_RST,
    output logic [N-1:0] O_UNIT_READY,
    output logic [N-1:0] O_UNIT_WE,
    output logic [N*8-1:0] O_UNIT_RDATA,
    output logic [N-1:0] O_UNIT_DOUT,
    output logic O_ANALOG_EN,
    output logic O_SYSCLK_NET_EN
);

    // ============================================================
    // Register file and bus slave state
    logic [7:0] ctrl0; // Misc unit disables
    logic [7:0] timers; // Oscillator and timer disables
    logic [7:0] next_ctrl0;
    logic [7:0] next_timers;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [N-1:0] unit_off; // One disable bit per unit

    // Address decode, shared by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ADDR_CTRL0) || (a == ADDR_TIMERS);
    endfunction

    // Widen one bit per unit to a byte lane mask over the read data lanes
    function automatic logic [N*8-1:0] byte_mask(input logic [N-1:0] off);
        for (int i = 0; i < N; i++) begin
            byte_mask[i*8 +: 8] = {8{off[i]}};
        end
    endfunction

    // Gather disable bits into unit order
    always_comb begin
        unit_off = '0;
        unit_off[UNIT_PIN_CHANGE] = ctrl0[PIN_CHANGE_IRQ_OFF_BIT];
        unit_off[UNIT_CLOCK_REF] = ctrl0[CLOCK_REF_OUT_OFF_BIT];
        unit_off[UNIT_NVM] = ctrl0[NONVOLATILE_UNIT_OFF_BIT];
        unit_off[UNIT_VREF] = ctrl0[VOLTAGE_REF_OFF_BIT];
        unit_off[UNIT_NUMERIC_OSC:UNIT_TIMER0] = timers;
    end

    // Next register and bus answer values
    always_comb begin
        next_ctrl0 = ctrl0;
        next_timers = timers;
        next_prdata = O_PRDATA;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (I_PSEL && !I_PENABLE) begin
            // Setup phase: answer is prepared for the access edge
            next_pready = 1'b1;
            next_pslverr = !is_mapped(I_PADDR);
            next_prdata = RDATA_ZERO;
            if (!I_PWRITE && I_PADDR == ADDR_CTRL0) begin
                next_prdata[7:0] = ctrl0 & CTRL0_IMPL_MASK;
            end else if (!I_PWRITE && I_PADDR == ADDR_TIMERS) begin
                next_prdata[7:0] = timers;
            end
        end
        if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE) begin
            // Access edge: write lands here and only here
            if (I_PADDR == ADDR_CTRL0) begin
                next_ctrl0 = I_PWDATA[7:0] & CTRL0_IMPL_MASK;
            end else if (I_PADDR == ADDR_TIMERS) begin
                next_timers = I_PWDATA[7:0];
            end
        end
    end

    // Register stage; every reset source lands on I_RESETN
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl0 <= CTRL_RESET;
            timers <= CTRL_RESET;
            O_PRDATA <= RDATA_ZERO;
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            ctrl0 <= next_ctrl0;
            timers <= next_timers;
            O_PRDATA <= next_prdata;
            O_PREADY <= next_pready;
            O_PSLVERR <= next_pslverr;
        end
    end

    // ============================================================
    // Global controls
    logic next_analog_en;
    logic next_sysclk_en;

    always_comb begin
        next_analog_en = !ctrl0[VOLTAGE_REF_OFF_BIT];
        next_sysclk_en = !ctrl0[SYS_CLOCK_NET_OFF_BIT];
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_ANALOG_EN <= 1'b1;
            O_SYSCLK_NET_EN <= 1'b1;
        end else begin
            O_ANALOG_EN <= next_analog_en;
            O_SYSCLK_NET_EN <= next_sysclk_en;
        end
    end

    // ============================================================
    // Per-unit gating and start-up counters
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_unit
            logic [CNT_W-1:0] cnt; // Cycles left before the unit is usable
            logic [CNT_W-1:0] next_cnt;
            logic [CNT_W-1:0] start_val;
            logic next_clk_en;
            logic next_we;
            logic [7:0] next_rdata;
            logic next_dout;

            // Memory needs longer to wake than the rest
            assign start_val = (gi == UNIT_NVM) ? CNT_W'(NVM_CYCLES) : CNT_W'(INSTR_CYCLES);

            always_comb begin
                // Counter parks at the full delay while disabled
                if (unit_off[gi]) begin
                    next_cnt = start_val;
                end else if (cnt != '0) begin
                    next_cnt = cnt - CNT_W'(1);
                end else begin
                    next_cnt = cnt;
                end
                // Clock stops for the unit, or for the whole network
                next_clk_en = !unit_off[gi] && !(USES_SYSCLK[gi] && ctrl0[SYS_CLOCK_NET_OFF_BIT]);
                next_we = I_UNIT_WE[gi] && !unit_off[gi];
                next_rdata = unit_off[gi] ? 8'h00 : I_UNIT_RDATA[gi*8 +: 8];
                next_dout = I_UNIT_DOUT[gi] && !unit_off[gi];
            end

            // Reset held as long as the bit stays set, so a cleared bit
            // hands back a unit with power-on register values.
            always_ff @(posedge I_MCLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    cnt <= '0;
                    O_UNIT_CLK_EN[gi] <= 1'b1;
                    O_UNIT_RST[gi] <= 1'b0;
                    O_UNIT_READY[gi] <= 1'b0;
                    O_UNIT_WE[gi] <= 1'b0;
                    O_UNIT_RDATA[gi*8 +: 8] <= 8'h00;
                    O_UNIT_DOUT[gi] <= 1'b0;
                end else begin
                    cnt <= next_cnt;
                    O_UNIT_CLK_EN[gi] <= next_clk_en;
                    O_UNIT_RST[gi] <= unit_off[gi];
                    O_UNIT_READY[gi] <= !unit_off[gi] && (next_cnt == '0);
                    O_UNIT_WE[gi] <= next_we;
                    O_UNIT_RDATA[gi*8 +: 8] <= next_rdata;
                    O_UNIT_DOUT[gi] <= next_dout;
                end
            end
        end
    endgenerate

    // ============================================================
    // Assertions
    sequence timer0_reenabled;
        $fell(unit_off[UNIT_TIMER0]);
    endsequence

    sequence timer0_idle_start;
        !O_UNIT_READY[UNIT_TIMER0] [*8];
    endsequence

    clk_gate_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        ((O_UNIT_CLK_EN & $past(unit_off)) == '0))
        else $error("Disabled unit still clocked");

    rst_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        (unit_off[UNIT_NVM] [*3]) |=> O_UNIT_RST[UNIT_NVM])
        else $error("Disabled unit left out of reset");

    wr_block_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        ((O_UNIT_WE & $past(unit_off)) == '0))
        else $error("Write reached a disabled unit");

    rd_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        $past(unit_off[UNIT_NVM]) |-> O_UNIT_RDATA[UNIT_NVM*8 +: 8] == 8'h00)
        else $error("Disabled memory read not zero");

    dout_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        ((O_UNIT_DOUT & $past(unit_off)) == '0)
            && (!$past(ctrl0[VOLTAGE_REF_OFF_BIT]) || !O_ANALOG_EN))
        else $error("Disabled unit output not forced");

    start_delay_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        timer0_reenabled |-> timer0_idle_start ##[1:8] O_UNIT_READY[UNIT_TIMER0]
            or ##[1:16] unit_off[UNIT_TIMER0])
        else $error("Timer start-up delay wrong");

    sysclk_net_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        $rose(ctrl0[SYS_CLOCK_NET_OFF_BIT])
            |=> !O_SYSCLK_NET_EN && ((O_UNIT_CLK_EN & USES_SYSCLK[N-1:0]) == '0))
        else $error("System clock network still running");

    unimpl_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        (ctrl0 & ~CTRL0_IMPL_MASK) == 8'h00)
        else $error("Unbuilt control bits set");

    // Write access edge as the slave sees it: the only edge a write may land on
    sequence bus_write_edge;
        I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    endsequence

    // Read setup cycle aimed at the first control register
    sequence ctrl0_read_setup;
        I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == ADDR_CTRL0);
    endsequence

    // No disable here, so the values held during reset are checked too
    reg_reset_a: assert property (@(posedge I_MCLK)
        !I_RESETN |-> (ctrl0 == CTRL_RESET) && (timers == CTRL_RESET) && (O_UNIT_RST == '0))
        else $error("Disable bits not cleared in reset");

    // Reset output is the disable bit one cycle late, for every unit
    rst_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        O_UNIT_RST == $past(unit_off))
        else $error("Unit reset does not follow its bit");

    // Read data lanes of disabled units stay zero
    rdata_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        (O_UNIT_RDATA & byte_mask($past(unit_off))) == '0)
        else $error("Disabled unit read data not zero");

    // Start-up is never reported for a unit that was off
    ready_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        (O_UNIT_READY & $past(unit_off)) == '0)
        else $error("Ready shown for a disabled unit");

    // Reference enable mirrors its disable bit both ways
    analog_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        O_ANALOG_EN == !$past(ctrl0[VOLTAGE_REF_OFF_BIT]))
        else $error("Reference enable wrong");

    // Network enable mirrors its bit, so clearing the bit restores the clock
    net_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        O_SYSCLK_NET_EN == !$past(ctrl0[SYS_CLOCK_NET_OFF_BIT]))
        else $error("Clock network enable wrong");

    // A write to the timer register lands whole at the access edge
    timer_write_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        bus_write_edge ##0 (I_PADDR == ADDR_TIMERS) |=> timers == $past(I_PWDATA[7:0]))
        else $error("Timer register write lost");

    // Unbuilt bits are dropped on the way in
    ctrl0_write_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        bus_write_edge ##0 (I_PADDR == ADDR_CTRL0)
            |=> ctrl0 == ($past(I_PWDATA[7:0]) & CTRL0_IMPL_MASK))
        else $error("Control register write wrong");

    // Unbuilt bits read back as zero
    rd_unimpl_a: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
        ctrl0_read_setup |=> (O_PRDATA[7:0] & ~CTRL0_IMPL_MASK) == 8'h00)
        else $error("Unbuilt bits read back set");

endmodule

/* File: verification/pmd_unit_model.sv */
/*
 * Behavioural model of the twelve gated peripherals behind the block.
 * Assumes same system clock; each unit has one 8-bit register.
 */
module pmd_unit_model
    import pmd_pkg::*;
#(
    parameter logic [7:0] POR_VALUE = 8'h5a // Non-zero so forcing is visible
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [NUM_UNITS-1:0] i_clk_en,
    input wire logic [NUM_UNITS-1:0] i_rst,
    input wire logic [NUM_UNITS-1:0] i_we,
    output logic [NUM_UNITS*8-1:0] o_rdata,
    output logic [NUM_UNITS-1:0] o_dout
);
    // ============================================================
    // Unit registers
    logic [7:0] regs [NUM_UNITS];
    logic [7:0] next_regs [NUM_UNITS];
    // Reset wins; a write counts only while the unit is clocked
    always_comb begin
        for (int i = 0; i < NUM_UNITS; i++) begin
            next_regs[i] = regs[i];
            if (i_rst[i]) next_regs[i] = POR_VALUE;
            else if (i_clk_en[i] && i_we[i]) next_regs[i] = regs[i] + 8'h01;
        end
    end
    // Registers only
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_UNITS; i++) regs[i] <= POR_VALUE;
        end else begin
            for (int i = 0; i < NUM_UNITS; i++) regs[i] <= next_regs[i];
        end
    end
    // Output idles high in reset so the block must force it low
    always_comb begin
        for (int i = 0; i < NUM_UNITS; i++) begin
            o_rdata[8*i+:8] = regs[i];
            o_dout[i] = ~regs[i][0];
        end
    end
endmodule

/* File: verification/tb.sv */
/*
 * Self-checking bench: APB master, random unit strobes, partner model.
 * Assumes the hand-over timing: zero-wait APB, one cycle gating latency.
 */
module tb import pmd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Signals
    logic clk = 1'b0, rstn = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000, we = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, analog_en, net_en;
    logic [11:0] clk_en, rst, rdy, o_we, dout, o_dout;
    logic [95:0] rdata, o_rdata;
    logic [7:0] c, t;
    localparam logic [7:0] POR = 8'h5a; // Partner's power-on register value
    int fail_count = 0, cmp_count = 0;
    initial forever #5 clk = ~clk;
    // Random core-side write strobes for units showing rdy or rst; a woken unit can take up to two of them before it reports ready
    always @(posedge clk) we <= 12'($urandom) & (rdy | rst);
    pmd_ctrl dut (.I_MCLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_UNIT_WE(we), .I_UNIT_RDATA(rdata),
        .I_UNIT_DOUT(dout), .O_UNIT_CLK_EN(clk_en), .O_UNIT_RST(rst), .O_UNIT_READY(rdy),
        .O_UNIT_WE(o_we), .O_UNIT_RDATA(o_rdata), .O_UNIT_DOUT(o_dout),
        .O_ANALOG_EN(analog_en), .O_SYSCLK_NET_EN(net_en));
    pmd_unit_model #(.POR_VALUE(POR)) model (.i_clk(clk), .i_resetn(rstn),
        .i_clk_en(clk_en), .i_rst(rst), .i_we(o_we), .o_rdata(rdata), .o_dout(dout));
    // ============================================================
    // Tasks
    task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Setup then access; holds everything until pready sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Idle edge so the next call never re-drives psel in this time step
        @(posedge clk);
    endtask
    // Compare unit gating for six cycles against the register values
    task automatic watch(input logic [7:0] c0, input logic [7:0] t0);
        logic [11:0] off, en, pd, pw;
        logic [95:0] pr, m;
        off = {t0, c0[6], c0[2:0]};
        en = ~off & {12{!c0[7]}};
        for (int i = 0; i < 12; i++) m[8*i+:8] = off[i] ? 8'h00 : 8'hff;
        @(negedge clk);
        repeat (6) begin
            pr = rdata;
            pd = dout;
            pw = we;
            @(negedge clk);
            chk("rdata", o_rdata, pr & m);
            chk("dout", o_dout, pd & ~off);
            chk("we", o_we, pw & ~off);
            chk("rst", rst, off);
            chk("clk_en", clk_en, en);
            chk("analog", analog_en, !c0[6]);
            chk("net", net_en, !c0[7]);
        end
        @(posedge clk);
    endtask
    // Re-enable one unit and time its start-up
    task automatic wake(input logic [11:0] a, input int u, input int cy);
        int n;
        apb(1'b1, a, 32'h0);
        @(posedge clk);
        chk("por", o_rdata[8*u+:8], POR);
        n = 1;
        while (rdy[u] !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("ready", n >= cy - 2 && n <= cy + 2, 1'b1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // Sequence; a woken unit can take up to two strobes before the bench sees it ready
    initial begin
        void'($urandom(47202));
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            apb(1'b0, ADDR_CTRL0, 32'h0);
            chk("ctrl0", rd, 0);
            apb(1'b0, ADDR_TIMERS, 32'h0);
            chk("timers", rd, 0);
            watch(8'h00, 8'h00);
            $display("test reset %0d done", r);
            // Corner one-hot values first, then random
            for (int k = 0; k < 28 && r == 0; k++) begin
                c = k < 8 ? 8'h01 << k : 8'($urandom);
                t = k < 8 ? 8'h01 << k : 8'($urandom);
                apb(1'b1, ADDR_CTRL0, {24'($urandom), c});
                apb(1'b1, ADDR_TIMERS, {24'h0, t});
                apb(1'b0, ADDR_CTRL0, 32'h0);
                chk("ctrl0", rd, c & CTRL0_IMPL_MASK);
                apb(1'b0, ADDR_TIMERS, 32'h0);
                chk("timers", rd, t);
                watch(c, t);
            end
            // Mid-run reset, with bits still set on the first pass
            rstn <= 1'b0;
            repeat (3) @(posedge clk);
            chk("reset rst", {rst, rdy, o_we}, 36'h0);
            chk("reset en", {clk_en, analog_en, net_en}, 14'h3fff);
            rstn <= 1'b1;
        end
        $display("test random gating done");
        apb(1'b1, 12'h008, 32'hff);
        chk("err", er, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped", {er, rd}, {1'b1, 32'h0});
        apb(1'b1, ADDR_CTRL0, 32'h04);
        apb(1'b1, ADDR_TIMERS, 32'h01);
        repeat (4) @(posedge clk);
        wake(ADDR_TIMERS, UNIT_TIMER0, INSTR_CYCLES);
        wake(ADDR_CTRL0, UNIT_NVM, NVM_CYCLES);
        $display("test wake done");
        summarize();
    end
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
